// ---- logic/dac_store_defs.vh ----
// dac_store_defs.vh: constants for the two-wire dac setting store
// assumes: included by bare name from files under logic/
`ifndef DAC_STORE_DEFS_VH
`define DAC_STORE_DEFS_VH
`define SLAVE_ADDR7       7'h4f
`define CODE_W            7
`define CODE_RESET        7'h00
`define NV_RESET          7'h40
`define NV_PROG_TIME_US   5
`define CLK_MHZ           125
`define NV_PROG_CYCLES    (`NV_PROG_TIME_US * `CLK_MHZ)
`define PSEL_REG_ONLY     1'b1
`define PSEL_READY        1'b1
`endif

// ---- logic/pin_sync.v ----
// pin_sync.v: two-flop synchroniser with a registered edge finder
// assumes: input comes from outside the clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter [0:0] IDLE_LEVEL = 1'b1
) (
  input  wire clk_sys,
  input  wire rst_b,
  input  wire pinIn,
  output reg  level,
  output reg  rise,
  output reg  fall
);
  reg stage1;
  reg stage2;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= IDLE_LEVEL;
      stage2 <= IDLE_LEVEL;
      level  <= IDLE_LEVEL;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      level  <= stage2;
      rise   <= stage2 & ~level;
      fall   <= ~stage2 & level;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ---- logic/dac_setting_store_i2c_slave.v ----
// dac_setting_store_i2c_slave.v: two-wire slave keeping a 7-bit dac code
// assumes: clk_sys far faster than the serial clock; pins are raw inputs
// Overview of operation
// - volatile 7-bit code drives 128 current steps
// - serial write updates register, optionally nonvolatile store
// - start-up copies nonvolatile store into register
// - read returns present setting to master
// - protect low refuses nonvolatile programming
// - protect high allows store per select flag
// - protect high routes switched clock to clock
// - protect output is inverse of protect input
// - slave only, answers address 9e
// - byte is seven code bits then flag
// - rw one reads, zero writes
// - flag one register only, zero adds store
// - read flag one ready, zero busy
`timescale 1ns/1ps
`default_nettype none
`include "dac_store_defs.vh"
module dac_setting_store_i2c_slave #(
  parameter NV_PROG_CYCLES = `NV_PROG_CYCLES
) (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire       sclIn,
  input  wire       sclSwIn,
  input  wire       sdaIn,
  output reg        sdaOut,
  output reg        sdaOe,
  input  wire       wpNotIn,
  output reg        wpOut,
  output reg  [6:0] dacCode,
  output reg  [6:0] nvStore,
  output reg        nvBusy
);
  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_ADDR = 5'h02;
  localparam [4:0] S_ACK  = 5'h04;
  localparam [4:0] S_RX   = 5'h08;
  localparam [4:0] S_TX   = 5'h10;
  wire wpLvl;
  wire sclMain;
  wire sclMainRise;
  wire sclMainFall;
  wire sclSw;
  wire sclSwRise;
  wire sclSwFall;
  wire sdaLvl;
  wire sdaRise;
  wire sdaFall;
  pin_sync uSyncScl (.clk_sys(clk_sys), .rst_b(rst_b), .pinIn(sclIn),
    .level(sclMain), .rise(sclMainRise), .fall(sclMainFall));
  pin_sync uSyncSw (.clk_sys(clk_sys), .rst_b(rst_b), .pinIn(sclSwIn),
    .level(sclSw), .rise(sclSwRise), .fall(sclSwFall));
  pin_sync uSyncSda (.clk_sys(clk_sys), .rst_b(rst_b), .pinIn(sdaIn),
    .level(sdaLvl), .rise(sdaRise), .fall(sdaFall));
  // protect pin idles low through its pull-down, so no false level after reset
  pin_sync #(.IDLE_LEVEL(1'b0)) uSyncWp (.clk_sys(clk_sys), .rst_b(rst_b), .pinIn(wpNotIn),
    .level(wpLvl), .rise(), .fall());
  // clock select: switched clock while protect pin high
  wire sclLvl  = wpLvl ? sclSw : sclMain;
  wire sclRise = wpLvl ? sclSwRise : sclMainRise;
  wire sclFall = wpLvl ? sclSwFall : sclMainFall;
  wire startCond = sdaFall & sclLvl;
  wire stopCond  = sdaRise & sclLvl;
  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  reg [4:0] state;
  reg [7:0] shift;
  reg [3:0] bitCnt;
  reg       readMode;
  reg       ackData;
  reg       loaded;
  reg [31:0] progCnt;
  // ----------------------------------------------------------------
  // read byte: code then programming state flag
  // ----------------------------------------------------------------
  function [7:0] readByte;
    input [6:0] code;
    input       busy;
    begin
      readByte = {code, busy ? ~`PSEL_READY : `PSEL_READY};
    end
  endfunction
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state    <= S_IDLE;
      shift    <= 8'h00;
      bitCnt   <= 4'h0;
      readMode <= 1'b0;
      ackData  <= 1'b0;
      sdaOut   <= 1'b0;
      sdaOe    <= 1'b0;
      wpOut    <= 1'b1;
      dacCode  <= `CODE_RESET;
      nvStore  <= `NV_RESET;
      nvBusy   <= 1'b0;
      loaded   <= 1'b0;
      progCnt  <= 32'h0;
    end else begin
      wpOut <= ~wpLvl;
      if (!loaded) begin
        loaded  <= 1'b1;
        dacCode <= nvStore;
      end
      if (nvBusy) begin
        if (progCnt == 32'h1)
          nvBusy <= 1'b0;
        progCnt <= progCnt - 32'h1;
      end
      if (startCond) begin
        state  <= S_ADDR;
        bitCnt <= 4'h0;
        sdaOe  <= 1'b0;
      end else if (stopCond) begin
        state <= S_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state)
          S_ADDR, S_RX: begin
            if (sclRise) begin
              shift  <= {shift[6:0], sdaLvl};
              bitCnt <= bitCnt + 4'h1;
            end
            if (sclFall && bitCnt == 4'h8) begin
              bitCnt <= 4'h0;
              if (state == S_ADDR) begin
                if (shift[7:1] == `SLAVE_ADDR7) begin
                  readMode <= shift[0];
                  ackData  <= 1'b0;
                  sdaOe    <= 1'b1;
                  state    <= S_ACK;
                end else
                  state <= S_IDLE;
              end else begin
                dacCode <= shift[7:1];
                if (shift[0] != `PSEL_REG_ONLY && wpLvl && !nvBusy) begin
                  nvStore <= shift[7:1];
                  nvBusy  <= 1'b1;
                  progCnt <= NV_PROG_CYCLES;
                end
                ackData <= 1'b1;
                sdaOe   <= 1'b1;
                state   <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (sclFall) begin
              if (readMode && !ackData) begin
                shift  <= readByte(dacCode, nvBusy);
                sdaOe  <= ~dacCode[6];
                bitCnt <= 4'h1;
                state  <= S_TX;
              end else begin
                sdaOe <= 1'b0;
                state <= S_RX;
              end
            end
          end
          S_TX: begin
            if (sclFall) begin
              if (bitCnt == 4'h8) begin
                sdaOe  <= 1'b0;
                bitCnt <= 4'h9;
              end else if (bitCnt == 4'h9) begin
                bitCnt <= 4'h0;
                if (sdaLvl)
                  state <= S_IDLE;
                else begin
                  shift  <= readByte(dacCode, nvBusy);
                  sdaOe  <= ~dacCode[6];
                  bitCnt <= 4'h1;
                end
              end else begin
                sdaOe  <= ~shift[7 - bitCnt[2:0]];
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          default: sdaOe <= 1'b0;
        endcase
      end
    end
  end
endmodule // dac_setting_store_i2c_slave
`default_nettype wire

// ---- sim/bus_master.sv ----
// bus_master: behavioural two-wire bus master
// assumes: data line has a pull-up; the slave pulls it low through sdaOe
`timescale 1ns/1ps
`default_nettype none
module bus_master (
  output var  logic scl,
  output var  logic sda,
  input  wire logic sdaOe
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic go();
    sda = 1'b0;
    #24 scl = 1'b0;
    #16;
  endtask
  task automatic halt();
    sda = 1'b0;
    #24 scl = 1'b1;
    #24 sda = 1'b1;
    #32;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda = tx[i];
      #24 scl = 1'b1;
      #40 rx[i] = sda & ~sdaOe;
      scl = 1'b0;
      #16;
    end
  endtask
endmodule // bus_master
`default_nettype wire

// ---- sim/dac_store_properties.sv ----
// checker: port properties of the dac setting store
// assumes: bound into every instance of the slave
`timescale 1ns/1ps
`default_nettype none
module dac_store_properties #(parameter int NV_PROG_CYCLES = 625) (
  input wire logic       clk_sys, rst_b, sdaOut, sdaOe, wpNotIn, wpOut, nvBusy,
  input wire logic [6:0] dacCode, nvStore
);
  int busyLen;
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) busyLen <= 0;
    else busyLen <= nvBusy ? busyLen + 1 : 0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_WP_INV: assert property ($stable(wpNotIn) [*6] |-> wpOut != wpNotIn)
    else $error("wpOut");
  AST_SDA_LOW: assert property (sdaOut == 1'b0)
    else $error("sdaOut");
  AST_COPY: assert property ($rose(rst_b) |=> dacCode == nvStore)
    else $error("copy");
  AST_NV_LOCK: assert property (!wpNotIn && !$past(wpNotIn, 8) |-> $stable(nvStore))
    else $error("nv lock");
  AST_NV_SAME: assert property ($changed(nvStore) |-> nvStore == dacCode)
    else $error("nv value");
  AST_BUSY_WP: assert property ($rose(nvBusy) |-> wpNotIn)
    else $error("busy wp");
  AST_BUSY_LEN: assert property ($fell(nvBusy) |->
    $past(busyLen) inside {[NV_PROG_CYCLES - 3 : NV_PROG_CYCLES + 3]}) else $error("busy");
  AST_DAC_ACK: assert property ($changed(dacCode) && $past(rst_b, 2) |-> ##[0:8] sdaOe)
    else $error("dac ack");
  AST_ACK_HOLD: assert property ($rose(sdaOe) |-> sdaOe [*8])
    else $error("ack");
  cover property ($rose(nvBusy));
  cover property ($changed(dacCode));
  cover property ($rose(sdaOe));
endmodule // dac_store_properties
bind dac_setting_store_i2c_slave dac_store_properties #(.NV_PROG_CYCLES(NV_PROG_CYCLES))
  props_i (.clk_sys(clk_sys), .rst_b(rst_b), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .wpNotIn(wpNotIn), .wpOut(wpOut), .nvBusy(nvBusy), .dacCode(dacCode), .nvStore(nvStore));
`default_nettype wire

// ---- sim/dac_setting_store_i2c_slave_bench.sv ----
// bench: writes, stores and reads back settings through the bus master model
// assumes: design, master model and checker compiled before this file
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module dac_setting_store_i2c_slave_bench;
  logic       clk_sys, rst_b, wpNotIn, scl, sda, sdaOut, sdaOe, wpOut, nvBusy, ackA;
  logic [6:0] dacCode, nvStore;
  logic [7:0] b;
  logic [8:0] rx;
  int         fail_count, total_checks, cycles;
  // protect, code, flag, expected store
  logic [15:0] rows [4] = '{16'hff7f, 16'h007f, 16'h95ff, 16'haa2a};
  dac_setting_store_i2c_slave #(.NV_PROG_CYCLES(300)) dac_setting_store_i2c_slave_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .sclIn(wpNotIn ? 1'b1 : scl),
    .sclSwIn(wpNotIn ? scl : 1'b1), .sdaIn(sda & ~sdaOe), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .wpNotIn(wpNotIn), .wpOut(wpOut), .dacCode(dacCode),
    .nvStore(nvStore), .nvBusy(nvBusy));
  bus_master bus_master_i (.scl(scl), .sda(sda), .sdaOe(sdaOe));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (++cycles == 20000) begin
    fail_count++;
    wrap_up();
  end
  task automatic wrap_up();
    $display("checks=%0d failures=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    bus_master_i.go();
    bus_master_i.xfer({adr, 1'b1}, rx);
    ackA = rx[0];
    bus_master_i.xfer({dat, 1'b1}, rx);
    bus_master_i.halt();
  endtask
  task automatic rd();
    bus_master_i.go();
    bus_master_i.xfer(9'h13f, rx);
    bus_master_i.xfer(9'h1ff, rx);
    b = rx[8:1];
    bus_master_i.halt();
  endtask
  initial begin
    rst_b = 1'b0;
    wpNotIn = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK(dacCode, 7'h40)
    `CHK(sdaOut, 1'b0)
    `CHK(nvBusy, 1'b0)
    foreach (rows[n]) begin
      wpNotIn = rows[n][15];
      repeat (8) @(negedge clk_sys);
      `CHK(wpOut, ~rows[n][15])
      wr(8'h9e, rows[n][14:7]);
      `CHK(ackA, 1'b0)
      repeat (350) @(negedge clk_sys);
      `CHK(dacCode, rows[n][14:8])
      `CHK(nvStore, rows[n][6:0])
      rd();
      `CHK(b, {rows[n][14:8], 1'b1})
    end
    wr(8'h9c, 8'h10);
    `CHK(ackA, 1'b1)
    `CHK(dacCode, 7'h2a)
    wr(8'h9e, 8'h30);
    rd();
    `CHK(b, 8'h30)
    wrap_up();
  end
endmodule // dac_setting_store_i2c_slave_bench
`default_nettype wire
